//--- bench/gpt_checker.sv
// Checker for the timer block: bus answers, read widths, latch, interrupt.
// Assumes it is bound to gpt_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module gpt_checker #(
  parameter int NT = 3
) (
  input wire logic          i_clk_sys,
  input wire logic          i_rst_n,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          i_pwrite,
  input wire logic [7:0]    i_paddr,
  input wire logic [31:0]   i_pwdata,
  input wire logic [31:0]   o_prdata,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  input wire logic [NT-1:0] i_timer_input_pin,
  input wire logic [NT-1:0] i_direction_input_pin,
  input wire logic          o_toggle_output_pin,
  input wire logic          o_irq
);
  logic acc;
  logic rd;
  logic ok;
  assign acc = i_psel && i_penable;
  assign rd  = acc && !i_pwrite;
  assign ok  = i_paddr[1:0] == 2'b00 && i_paddr <= 8'h20;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  AST_READY: assert property (i_psel && !i_penable |=> o_pready)
    else $error("setup cycle not answered after one access cycle");
  AST_UNMAPPED: assert property (acc && !ok |-> o_pslverr &&
    (i_pwrite || o_prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc && ok |-> !o_pslverr)
    else $error("mapped access refused");
  AST_CNT_WIDTH: assert property (
    rd && i_paddr inside {8'h0C, 8'h10, 8'h14} |-> o_prdata[31:16] == 16'h0)
    else $error("count read wider than sixteen bits");
  AST_CTRL_WIDTH: assert property (
    rd && i_paddr inside {8'h00, 8'h04, 8'h08} |-> o_prdata[31:16] == 16'h0)
    else $error("control read wider than sixteen bits");
  AST_STAT_WIDTH: assert property (
    rd && i_paddr inside {8'h18, 8'h1C} |-> o_prdata[31:5] == 27'h0)
    else $error("flag read wider than five bits");
  AST_LATCH_READ: assert property (rd && i_paddr == 8'h20 |->
    o_prdata == {31'h0, $past(o_toggle_output_pin)})
    else $error("latch read differs from toggle pin");
  AST_MASK_OFF: assert property (acc && i_pwrite &&
    i_paddr == 8'h1C && i_pwdata[4:0] == 5'h00 |=> !o_irq [*2])
    else $error("interrupt high with every flag masked");
endmodule : gpt_checker
bind gpt_top gpt_checker #(.NT(NT)) i_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_timer_input_pin(i_timer_input_pin),
  .i_direction_input_pin(i_direction_input_pin),
  .o_toggle_output_pin(o_toggle_output_pin), .o_irq(o_irq));
`default_nettype wire

//--- bench/gpt_pin_src.sv
// Far-side model: quadrature position sensor and event signal sources.
// Assumes callers run on the system clock; pins change after its edge.
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_src (
  input  wire logic       i_clk_sys,
  output logic      [2:0] o_tin,
  output logic      [2:0] o_tdir
);
  int k[3] = '{0, 0, 0};
  initial begin
    o_tin = 3'h0;
    o_tdir = 3'h0;
  end
  // Four cycles per level so synchroniser and edge detector both see it
  task automatic hold;
    repeat (4) @(posedge i_clk_sys);
  endtask : hold
  task automatic set_lvl(input int i, input logic a, input logic b);
    @(posedge i_clk_sys);
    o_tin[i] <= a;
    o_tdir[i] <= b;
    hold();
  endtask : set_lvl
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge i_clk_sys);
      o_tin[i] <= 1'b1;
      hold();
      o_tin[i] <= 1'b0;
      hold();
    end
  endtask : pulse
  // Forward motion: signal A leads B by a quarter period
  task automatic quad(input int i, input int n, input bit fwd);
    repeat (n) begin
      k[i] = fwd ? (k[i] + 1) % 4 : (k[i] + 3) % 4;
      @(posedge i_clk_sys);
      o_tin[i] <= (k[i] == 1 || k[i] == 2);
      o_tdir[i] <= (k[i] >= 2);
      hold();
    end
  endtask : quad
endmodule : gpt_pin_src
`default_nettype wire

//--- bench/gpt_top_bench.sv
// Self-checking bench of the timer block over its register bus and pins.
// Assumes the pin source model drives every timer pin.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, y) begin checked++; if ((y) !== (x)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", nm, x, y); end end
module gpt_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic        pready;
  logic        pslverr;
  logic        e;
  logic        tpin;
  logic        irq;
  logic [2:0]  tin;
  logic [2:0]  tdir;
  int          num_errors = 0;
  int          checked = 0;
  int          n;
  initial begin
    forever #5 clk = ~clk;
  end
  gpt_top i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_timer_input_pin(tin), .i_direction_input_pin(tdir),
    .o_toggle_output_pin(tpin), .o_irq(irq));
  gpt_pin_src i_src (.i_clk_sys(clk), .o_tin(tin), .o_tdir(tdir));
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    #1;
  endtask : bus
  task automatic wait_pin(input logic v);
    n = 0;
    while (tpin !== v && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_pin
  task automatic measure(input logic [15:0] ctl, input logic lvl,
                         input logic dir, input logic [15:0] want);
    logic [15:0] c0;
    i_src.set_lvl(0, lvl, dir);
    bus(1'b1, 8'h0C, 32'h8000);
    bus(1'b1, 8'h00, {16'h0, ctl});
    bus(1'b0, 8'h0C, 32'h0);
    c0 = q[15:0];
    repeat (253) @(posedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    `CHK("count delta", want, q[15:0] - c0)
  endtask : measure
  task automatic t_reset;
    for (int a = 0; a <= 36; a += 4) begin
      bus(1'b0, 8'(a), 32'h0);
      `CHK("reset value", 32'h0, q)
      `CHK("slave error", (a == 36), e)
    end
    bus(1'b1, 8'h10, 32'h1FFFF);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("count width", 32'hFFFF, q)
    bus(1'b1, 8'h10, 32'h0);
  endtask : t_reset
  task automatic t_timer;
    measure(16'h0080, 1'b0, 1'b0, 16'h0020);
    measure(16'h0084, 1'b0, 1'b0, 16'h0010);
    measure(16'h00A0, 1'b0, 1'b0, 16'hFFE0);
    measure(16'h00C0, 1'b0, 1'b1, 16'hFFE0);
    measure(16'h00C0, 1'b0, 1'b0, 16'h0020);
    measure(16'h0081, 1'b0, 1'b0, 16'h0000);
    measure(16'h0081, 1'b1, 1'b0, 16'h0020);
    measure(16'h1081, 1'b1, 1'b0, 16'h0000);
    bus(1'b1, 8'h00, 32'h0);
    i_src.set_lvl(0, 1'b0, 1'b0);
  endtask : t_timer
  task automatic t_count;
    bus(1'b1, 8'h04, 32'h0182);
    i_src.pulse(1, 5);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("rising events", 32'h5, q)
    bus(1'b1, 8'h04, 32'h0382);
    i_src.pulse(1, 3);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("both edge events", 32'hB, q)
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h08, 32'h83);
    i_src.quad(2, 8, 1'b1);
    bus(1'b0, 8'h14, 32'h0);
    `CHK("encoder forward", 32'h8, q)
    i_src.quad(2, 3, 1'b0);
    bus(1'b0, 8'h14, 32'h0);
    `CHK("encoder reverse", 32'h5, q)
    bus(1'b1, 8'h08, 32'h0);
  endtask : t_count
  task automatic t_wrap;
    bus(1'b1, 8'h10, 32'h0);
    bus(1'b1, 8'h04, 32'h8382);
    bus(1'b1, 8'h1C, 32'h1F);
    bus(1'b1, 8'h0C, 32'hFFFF);
    bus(1'b1, 8'h00, 32'h80);
    wait_pin(1'b1);
    bus(1'b1, 8'h00, 32'h0);
    `CHK("irq on overflow", 1'b1, irq)
    bus(1'b0, 8'h18, 32'h0);
    `CHK("overflow flag", 32'h1, q)
    bus(1'b0, 8'h0C, 32'h0);
    `CHK("wrapped up", 8'h00, q[15:8])
    bus(1'b0, 8'h20, 32'h0);
    `CHK("latch set", 32'h1, q)
    bus(1'b1, 8'h18, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
    bus(1'b1, 8'h0C, 32'h0);
    bus(1'b1, 8'h00, 32'hA0);
    wait_pin(1'b0);
    bus(1'b1, 8'h00, 32'h0);
    `CHK("latch on underflow", 1'b0, tpin)
    bus(1'b0, 8'h0C, 32'h0);
    `CHK("wrapped down", 8'hFF, q[15:8])
    bus(1'b1, 8'h1C, 32'h0);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b0, 8'h10, 32'h0);
    `CHK("chained count", 32'h2, q)
    bus(1'b1, 8'h18, 32'h1F);
  endtask : t_wrap
  task automatic t_roles;
    bus(1'b1, 8'h0C, 32'h1234);
    bus(1'b1, 8'h04, 32'h0980);
    i_src.pulse(1, 1);
    bus(1'b0, 8'h18, 32'h0);
    `CHK("capture flag", 32'h8, q)
    repeat (40) @(posedge clk);
    bus(1'b0, 8'h10, 32'h0);
    `CHK("captured count", 32'h1234, q)
    bus(1'b1, 8'h18, 32'h1F);
    bus(1'b1, 8'h10, 32'h4321);
    bus(1'b1, 8'h04, 32'h0500);
    i_src.pulse(1, 1);
    bus(1'b0, 8'h0C, 32'h0);
    `CHK("pin reload", 32'h4321, q)
    bus(1'b1, 8'h10, 32'hFFF0);
    bus(1'b1, 8'h14, 32'hFFF8);
    bus(1'b1, 8'h04, 32'h2400);
    bus(1'b1, 8'h08, 32'h6400);
    bus(1'b1, 8'h0C, 32'hFFFF);
    bus(1'b1, 8'h00, 32'h80);
    wait_pin(1'b1);
    wait_pin(1'b0);
    `CHK("pwm high time", 128, n)
    wait_pin(1'b1);
    `CHK("pwm low time", 64, n)
    bus(1'b1, 8'h00, 32'h0);
  endtask : t_roles
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer();
    t_count();
    t_wrap();
    t_roles();
    give_verdict();
  end
endmodule : gpt_top_bench
`default_nettype wire

//--- verilog/gpt_cnt_if.sv
// Link between the timer control logic and one counter unit.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface gpt_cnt_if #(parameter int W = 16);
  logic         step;
  logic         up;
  logic         load;
  logic [W-1:0] load_val;
  logic [W-1:0] cnt;
  logic         wrap;

  modport ctl (output step, output up, output load, output load_val,
               input cnt, input wrap);
  modport tmr (input step, input up, input load, input load_val,
               output cnt, output wrap);
endinterface : gpt_cnt_if
`default_nettype wire

//--- verilog/gpt_defines.svh
// Constants of the general purpose timer block: register offsets,
// control field positions, reset values and timing counts.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
//
// What this block does
// RULE_01: Three independent timers, each with its own 16-bit count.
// RULE_02: Each timer runs as timer, gated timer, counter or encoder.
// RULE_03: Free timer mode counts system clocks divided by a chosen prescale.
// RULE_04: Event counter mode counts selected edges on the timer input pin.
// RULE_05: Gated mode counts prescaled clocks only while the gate allows.
// RULE_06: Fastest timer counting is one step per sixteen base time units.
// RULE_07: Software sets direction; direction pin may invert it at run time.
// RULE_08: Encoder mode takes step and direction from two quadrature signals.
// RULE_09: Core toggle latch flips on every core overflow or underflow.
// RULE_10: Latch drives an output pin and can clock either auxiliary timer.
// RULE_11: Auxiliary timer in capture or reload role does not count itself.
// RULE_12: Capture role latches core count on selected input pin edge.
// RULE_13: Reload role loads core from auxiliary on pin or latch edge.
// RULE_14: Two auxiliaries reloading on opposite latch edges make PWM unaided.
// RULE_15: A timer can be chained so core overflows drive another's counting.
// RULE_16: Up from FFFF wraps to 0000 as overflow; down wraps as underflow.
// RULE_17: Each timer flags overflow or underflow; auxiliaries flag captures.
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

`define GPT_OFS_CTRL_CORE  8'h00
`define GPT_OFS_CTRL_AUXA  8'h04
`define GPT_OFS_CTRL_AUXB  8'h08
`define GPT_OFS_CNT_CORE   8'h0C
`define GPT_OFS_CNT_AUXA   8'h10
`define GPT_OFS_CNT_AUXB   8'h14
`define GPT_OFS_IRQ_STAT   8'h18
`define GPT_OFS_IRQ_MASK   8'h1C
`define GPT_OFS_LATCH      8'h20

`define GPT_F_MODE_LSB     0
`define GPT_F_PSC_LSB      2
`define GPT_F_DOWN         5
`define GPT_F_EXTDIR       6
`define GPT_F_RUN          7
`define GPT_F_EDGE_LSB     8
`define GPT_F_ROLE_LSB     10
`define GPT_F_GPOL         12
`define GPT_F_RLD_TL       13
`define GPT_F_TL_FALL      14
`define GPT_F_SRC_TL       15

`define GPT_CTRL_RST       16'h0000
`define GPT_CNT_RST        16'h0000
`define GPT_IRQ_RST        5'h00

`define GPT_CLK_PERIOD_NS  10
`define GPT_TCL_NS         5
`define GPT_RES_TCL        16
`define GPT_MIN_DIV \
  ((`GPT_RES_TCL * `GPT_TCL_NS + `GPT_CLK_PERIOD_NS - 1) / `GPT_CLK_PERIOD_NS)

`endif

//--- verilog/gpt_pkg.sv
// Types shared by the general purpose timer block.
// Assumes nothing beyond a SystemVerilog tool.
package gpt_pkg;
  typedef enum logic [1:0] {
    GPT_MODE_TIMER,
    GPT_MODE_GATED,
    GPT_MODE_COUNT,
    GPT_MODE_ENC
  } gpt_mode_e;

  typedef enum logic [1:0] {
    GPT_ROLE_NORMAL,
    GPT_ROLE_RELOAD,
    GPT_ROLE_CAPTURE
  } gpt_role_e;
endpackage : gpt_pkg

//--- verilog/gpt_timer.sv
// One up/down counter unit with load, wrap detection and step control.
// Assumes step and load come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gpt_timer #(
  parameter int W = 16
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  gpt_cnt_if.tmr    bus
);
  logic [W-1:0] cnt_q;

  // Load wins over a step in the same cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (bus.load) begin
      cnt_q <= bus.load_val;
    end else if (bus.step) begin
      cnt_q <= bus.up ? cnt_q + 1'b1 : cnt_q - 1'b1; // [RULE_16]
    end
  end

  assign bus.cnt  = cnt_q;
  // A load does not hide the wrap: the core reload is itself triggered by
  // the wrap, so gating on load would close a combinational loop
  assign bus.wrap = bus.step &
                    (bus.up ? (&cnt_q) : (cnt_q == '0)); // [RULE_16]
endmodule : gpt_timer
`default_nettype wire

//--- verilog/gpt_top.sv
// Timer module top: APB register file, pin synchronisers, prescaler,
// mode control of three timers, core toggle latch and interrupt.
// Assumes pins are asynchronous to i_clk_sys and an APB master on it.
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defines.svh"
module gpt_top #(
  parameter int NT    = 3,
  parameter int W     = 16,
  parameter int PSC_W = 11
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_rst_n,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic      [31:0]   o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  input  wire logic [NT-1:0] i_timer_input_pin,
  input  wire logic [NT-1:0] i_direction_input_pin,
  output logic               o_toggle_output_pin,
  output logic               o_irq
);
  import gpt_pkg::*;

  localparam int CORE = 0;
  localparam int AUXA = 1;
  localparam int AUXB = 2;
  localparam int NIRQ = 5;

  // Register state
  logic [15:0]     ctrl_q [NT];
  logic [NIRQ-1:0] stat_q;
  logic [NIRQ-1:0] mask_q;
  logic            tl_q;
  logic [31:0]     prdata_q;
  logic            pslverr_q;

  // Pin synchronisers: s1 is read only by s2
  logic [2*NT-1:0] pin_s1_q;
  logic [2*NT-1:0] pin_s2_q;
  logic [2*NT-1:0] pin_p_q;

  logic [PSC_W-1:0] psc_cnt_q;

  // Per-timer glue
  logic [NT-1:0]   sw_ld;
  logic [NT-1:0]   wrap;
  logic [NT-1:0]   reload_req;
  logic [NT-1:0]   cap_evt;
  logic [W-1:0]    cnt_v [NT];
  logic [NT-1:0]   tin;
  logic [NT-1:0]   dlv;
  logic [NT-1:0]   tin_r;
  logic [NT-1:0]   tin_f;
  logic [NT-1:0]   dlv_r;
  logic [NT-1:0]   dlv_f;
  logic            tl_rise;
  logic            tl_fall;

  // APB decode
  logic            apb_wr;
  logic            apb_setup;
  logic [5:0]      widx;
  logic            hit;
  logic [NIRQ-1:0] irq_set;
  logic [NIRQ-1:0] irq_clr;

  gpt_cnt_if #(.W(W)) u_if [NT] ();

  // Pin sampling
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_p_q  <= '0;
    end else begin
      pin_s1_q <= {i_direction_input_pin, i_timer_input_pin};
      pin_s2_q <= pin_s1_q;
      pin_p_q  <= pin_s2_q;
    end
  end

  assign tin   = pin_s2_q[NT-1:0];
  assign dlv   = pin_s2_q[2*NT-1:NT];
  assign tin_r = tin & ~pin_p_q[NT-1:0];
  assign tin_f = ~tin & pin_p_q[NT-1:0];
  assign dlv_r = dlv & ~pin_p_q[2*NT-1:NT];
  assign dlv_f = ~dlv & pin_p_q[2*NT-1:NT];

  // Free-running prescaler shared by all timers; each picks a tap
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      psc_cnt_q <= '0;
    end else begin
      psc_cnt_q <= psc_cnt_q + 1'b1;
    end
  end

  // Core toggle latch
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      tl_q <= 1'b0;
    end else if (wrap[CORE]) begin
      tl_q <= ~tl_q; // [RULE_09]
    end
  end

  // Transitions are taken in the wrap cycle so a reload lands on the
  // same edge the core would otherwise step past
  assign tl_rise             = wrap[CORE] & ~tl_q;
  assign tl_fall             = wrap[CORE] & tl_q;
  assign o_toggle_output_pin = tl_q; // [RULE_10]

  for (genvar i = 0; i < NT; i++) begin : g_tmr
    logic [15:0]      ctrl;
    gpt_mode_e        mode;
    gpt_role_e        role;
    logic [PSC_W-1:0] div_m;
    logic             tick;
    logic             pin_ev;
    logic             tl_ev;
    logic             dir_up;
    logic             q_step;
    logic             q_up;
    logic             step;
    logic             up;
    logic             ld;
    logic [W-1:0]     ld_val;

    assign ctrl = ctrl_q[i];

    always_comb begin
      mode = gpt_mode_e'(ctrl[`GPT_F_MODE_LSB +: 2]); // [RULE_02]
      if (i == CORE) begin
        role = GPT_ROLE_NORMAL;
      end else begin
        unique case (ctrl[`GPT_F_ROLE_LSB +: 2])
          2'h1:    role = GPT_ROLE_RELOAD;
          2'h2:    role = GPT_ROLE_CAPTURE;
          default: role = GPT_ROLE_NORMAL;
        endcase
      end
    end

    // Smallest tap is the 16 TCL resolution limit
    assign div_m = (PSC_W'(`GPT_MIN_DIV) << ctrl[`GPT_F_PSC_LSB +: 3])
                   - PSC_W'(1); // [RULE_06]
    assign tick  = (psc_cnt_q & div_m) == '0; // [RULE_03]

    assign pin_ev = (ctrl[`GPT_F_EDGE_LSB] & tin_r[i]) |
                    (ctrl[`GPT_F_EDGE_LSB + 1] & tin_f[i]);
    // Latch edges as a count source chain the core into this timer
    assign tl_ev  = (ctrl[`GPT_F_EDGE_LSB] & tl_rise) | // [RULE_10]
                    (ctrl[`GPT_F_EDGE_LSB + 1] & tl_fall); // [RULE_15]

    assign dir_up = ~(ctrl[`GPT_F_DOWN] ^
                      (ctrl[`GPT_F_EXTDIR] & dlv[i])); // [RULE_07]

    // Quadrature: A on the input pin, B on the direction pin, 4x decode
    assign q_step = tin_r[i] | tin_f[i] | dlv_r[i] | dlv_f[i]; // [RULE_08]
    assign q_up   = ~(pin_p_q[i] ^ dlv[i] ^ ctrl[`GPT_F_DOWN]); // [RULE_08]

    always_comb begin
      step = 1'b0;
      up   = dir_up;
      if (ctrl[`GPT_F_RUN] && role == GPT_ROLE_NORMAL) begin // [RULE_11]
        unique case (mode)
          GPT_MODE_TIMER: step = tick; // [RULE_03]
          GPT_MODE_GATED:
            step = tick & (tin[i] ^ ctrl[`GPT_F_GPOL]); // [RULE_05]
          GPT_MODE_COUNT:
            step = ctrl[`GPT_F_SRC_TL] ? tl_ev : pin_ev; // [RULE_04]
          GPT_MODE_ENC: begin
            step = q_step;
            up   = q_up;
          end
        endcase
      end
    end

    // Capture and reload triggers of the auxiliary timers
    always_comb begin
      cap_evt[i]    = 1'b0;
      reload_req[i] = 1'b0;
      if (i != CORE) begin
        cap_evt[i] = (role == GPT_ROLE_CAPTURE) & pin_ev; // [RULE_12]
        if (role == GPT_ROLE_RELOAD) begin
          reload_req[i] = ctrl[`GPT_F_RLD_TL] ?
            (ctrl[`GPT_F_TL_FALL] ? tl_fall : tl_rise) :
            pin_ev; // [RULE_13] [RULE_14]
        end
      end
    end

    // Software write of the count wins over any hardware load
    always_comb begin
      ld     = sw_ld[i];
      ld_val = i_pwdata[W-1:0];
      if (!sw_ld[i]) begin
        if (i == CORE) begin
          ld     = reload_req[AUXA] | reload_req[AUXB];
          ld_val = reload_req[AUXA] ? cnt_v[AUXA] : cnt_v[AUXB]; // [RULE_13]
        end else begin
          ld     = cap_evt[i];
          ld_val = cnt_v[CORE]; // [RULE_12]
        end
      end
    end

    assign u_if[i].step     = step;
    assign u_if[i].up       = up;
    assign u_if[i].load     = ld;
    assign u_if[i].load_val = ld_val;
    assign cnt_v[i]         = u_if[i].cnt;
    assign wrap[i]          = u_if[i].wrap;

    gpt_timer #(.W(W)) u_timer (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .bus       (u_if[i].tmr)
    ); // [RULE_01]
  end

  // APB slave: zero wait states, data registered in the setup cycle
  assign apb_setup = i_psel & ~i_penable;
  assign apb_wr    = i_psel & i_penable & i_pwrite;
  assign widx      = i_paddr[7:2];
  assign o_pready  = 1'b1;
  assign o_prdata  = prdata_q;
  assign o_pslverr = pslverr_q;

  always_comb begin
    unique case (i_paddr)
      `GPT_OFS_CTRL_CORE, `GPT_OFS_CTRL_AUXA, `GPT_OFS_CTRL_AUXB,
      `GPT_OFS_CNT_CORE, `GPT_OFS_CNT_AUXA, `GPT_OFS_CNT_AUXB,
      `GPT_OFS_IRQ_STAT, `GPT_OFS_IRQ_MASK, `GPT_OFS_LATCH: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    sw_ld = '0;
    if (apb_wr) begin
      unique case (i_paddr)
        `GPT_OFS_CNT_CORE: sw_ld[CORE] = 1'b1;
        `GPT_OFS_CNT_AUXA: sw_ld[AUXA] = 1'b1;
        `GPT_OFS_CNT_AUXB: sw_ld[AUXB] = 1'b1;
        default:           sw_ld       = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      for (int k = 0; k < NT; k++) begin
        ctrl_q[k] <= `GPT_CTRL_RST;
      end
      mask_q <= `GPT_IRQ_RST;
    end else if (apb_wr) begin
      unique case (i_paddr)
        `GPT_OFS_CTRL_CORE: ctrl_q[CORE] <= i_pwdata[15:0];
        `GPT_OFS_CTRL_AUXA: ctrl_q[AUXA] <= i_pwdata[15:0];
        `GPT_OFS_CTRL_AUXB: ctrl_q[AUXB] <= i_pwdata[15:0];
        `GPT_OFS_IRQ_MASK:  mask_q       <= i_pwdata[NIRQ-1:0];
        default:            mask_q       <= mask_q;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (apb_setup) begin
      pslverr_q <= ~hit;
      unique case (i_paddr)
        `GPT_OFS_CTRL_CORE: prdata_q <= {16'h0000, ctrl_q[CORE]};
        `GPT_OFS_CTRL_AUXA: prdata_q <= {16'h0000, ctrl_q[AUXA]};
        `GPT_OFS_CTRL_AUXB: prdata_q <= {16'h0000, ctrl_q[AUXB]};
        `GPT_OFS_CNT_CORE:  prdata_q <= {16'h0000, cnt_v[CORE]};
        `GPT_OFS_CNT_AUXA:  prdata_q <= {16'h0000, cnt_v[AUXA]};
        `GPT_OFS_CNT_AUXB:  prdata_q <= {16'h0000, cnt_v[AUXB]};
        `GPT_OFS_IRQ_STAT:  prdata_q <= {27'h0000000, stat_q};
        `GPT_OFS_IRQ_MASK:  prdata_q <= {27'h0000000, mask_q};
        `GPT_OFS_LATCH:     prdata_q <= {31'h00000000, tl_q};
        default:            prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt status: write one to clear, a new event beats the clear
  assign irq_set = {cap_evt[AUXB], cap_evt[AUXA], wrap}; // [RULE_17]
  assign irq_clr = (apb_wr && i_paddr == `GPT_OFS_IRQ_STAT) ?
                   i_pwdata[NIRQ-1:0] : '0;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stat_q <= `GPT_IRQ_RST;
    end else begin
      stat_q <= (stat_q & ~irq_clr) | irq_set; // [RULE_17]
    end
  end

  assign o_irq = |(stat_q & mask_q);

  logic unused_idx;
  assign unused_idx = ^widx;
endmodule : gpt_top
`default_nettype wire
